// file: port_cd_override.sv
`timescale 1ns/1ps
module port_cd_override
  import pinmux_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] PORTC_DATA,
  input wire logic [7:0] PORTC_DIRECTION,
  input wire logic [7:0] PORTD_DATA,
  input wire logic [7:0] PORTD_DIRECTION,
  input wire logic GLOBAL_PULLUP_DISABLE,
  input wire logic SLEEP_INPUT_DISABLE,
  input wire logic [7:0] PORTC_PIN_IN,
  input wire logic [7:0] PORTD_PIN_IN,
  input wire logic TWI_ENABLE_BIT,
  input wire logic TWI_SCL_PULL_LOW,
  input wire logic TWI_SDA_PULL_LOW,
  input wire logic TIMER2_ASYNC_SELECT,
  input wire logic TEST_PORT_ENABLE,
  input wire logic INSTR_SHIFT_STATE,
  input wire logic DATA_SHIFT_STATE,
  input wire logic TEST_DATA_OUT,
  input wire logic TIMER2_COMPARE_ENABLE,
  input wire logic TIMER2_COMPARE_OUT,
  input wire logic TIMER1_COMPARE_A_ENABLE,
  input wire logic TIMER1_COMPARE_A_OUT,
  input wire logic TIMER1_COMPARE_B_ENABLE,
  input wire logic TIMER1_COMPARE_B_OUT,
  input wire logic EXT_IRQ_ZERO_ENABLE,
  input wire logic EXT_IRQ_ONE_ENABLE,
  input wire logic UART_TX_ENABLE,
  input wire logic UART_TX_DATA,
  input wire logic UART_RX_ENABLE,
  output logic [7:0] PORTC_PIN_OUT,
  output logic [7:0] PORTC_PIN_OE,
  output logic [7:0] PORTC_PULLUP,
  output logic [7:0] PORTC_PIN_READ,
  output logic [7:0] PORTD_PIN_OUT,
  output logic [7:0] PORTD_PIN_OE,
  output logic [7:0] PORTD_PULLUP,
  output logic [7:0] PORTD_PIN_READ,
  output logic [1:0] TWI_SLEW_LIMIT,
  output logic TWI_SCL_IN,
  output logic TWI_SDA_IN,
  output logic TEST_TCK_IN,
  output logic TEST_TMS_IN,
  output logic TEST_TDI_IN,
  output logic TIMER1_CAPTURE_IN,
  output logic EXT_IRQ_ZERO_IN,
  output logic EXT_IRQ_ONE_IN,
  output logic UART_RX_DATA
);

  mux_state_s s_q;
  mux_state_s s_d;
  pin_ovr_s [7:0] ovr_c;
  pin_ovr_s [7:0] ovr_d;
  logic pu_off;
  logic die_norm;

  // each asserted enable takes its override, the rest stay with the port
  function automatic pin_ctl_s apply_ovr(
    input pin_ovr_s o,
    input logic port_bit,
    input logic dir_bit,
    input logic pull_dis,
    input logic die_base
  );
    pin_ctl_s c;
    logic pu_norm;
    pu_norm = port_bit & ~dir_bit & ~pull_dis;
    c.pu = o.pullup_override_enable ? o.pullup_override_value : pu_norm; // R17
    c.oe = o.direction_override_enable ? o.direction_override_value : dir_bit; // R17
    c.out = o.port_value_override_enable ? o.port_value_override_value : port_bit; // R17
    c.die = o.input_enable_override_enable ? o.input_enable_override_value : die_base; // R17
    return c;
  endfunction

  assign pu_off = GLOBAL_PULLUP_DISABLE;
  assign die_norm = ~SLEEP_INPUT_DISABLE;

  always_comb begin
    ovr_c = {8{OVR_NONE}};
    ovr_d = {8{OVR_NONE}};

    // two-wire pins: open drain, drive-low request steers direction
    ovr_c[PC_SCL] = '{
      pullup_override_enable: TWI_ENABLE_BIT,
      pullup_override_value: PORTC_DATA[PC_SCL] & ~pu_off, // R4
      direction_override_enable: TWI_ENABLE_BIT, // R1
      direction_override_value: TWI_SCL_PULL_LOW, // R3
      port_value_override_enable: TWI_ENABLE_BIT, // R1
      port_value_override_value: 1'b0, // R3
      input_enable_override_enable: 1'b0,
      input_enable_override_value: 1'b0
    };
    ovr_c[PC_SDA] = '{
      pullup_override_enable: TWI_ENABLE_BIT,
      pullup_override_value: PORTC_DATA[PC_SDA] & ~pu_off, // R4
      direction_override_enable: TWI_ENABLE_BIT,
      direction_override_value: TWI_SDA_PULL_LOW, // R3
      port_value_override_enable: TWI_ENABLE_BIT,
      port_value_override_value: 1'b0, // R3
      input_enable_override_enable: 1'b0,
      input_enable_override_value: 1'b0
    };

    // test port input pins: clock, mode select, data in
    for (int i = 0; i < 8; i++) begin
      if (TEST_PULLUP_MASK[i]) begin
        ovr_c[i] = '{
          pullup_override_enable: TEST_PORT_ENABLE,
          pullup_override_value: 1'b1, // R8
          direction_override_enable: TEST_PORT_ENABLE,
          direction_override_value: 1'b0,
          port_value_override_enable: 1'b0,
          port_value_override_value: 1'b0,
          input_enable_override_enable: TEST_PORT_ENABLE, // R8
          input_enable_override_value: 1'b0
        };
      end
    end
    ovr_c[PC_TDO] = '{
      pullup_override_enable: TEST_PORT_ENABLE,
      pullup_override_value: 1'b0, // R7
      direction_override_enable: TEST_PORT_ENABLE,
      direction_override_value: INSTR_SHIFT_STATE | DATA_SHIFT_STATE, // R7
      port_value_override_enable: TEST_PORT_ENABLE,
      port_value_override_value: TEST_DATA_OUT, // R7
      input_enable_override_enable: TEST_PORT_ENABLE,
      input_enable_override_value: 1'b0
    };

    // crystal pins of the asynchronous timer
    ovr_c[PC_OSC_IN] = '{
      pullup_override_enable: TIMER2_ASYNC_SELECT,
      pullup_override_value: 1'b0, // R6
      direction_override_enable: TIMER2_ASYNC_SELECT,
      direction_override_value: 1'b0, // R6
      port_value_override_enable: 1'b0,
      port_value_override_value: 1'b0,
      input_enable_override_enable: TIMER2_ASYNC_SELECT,
      input_enable_override_value: 1'b0 // R6
    };
    ovr_c[PC_OSC_OUT] = ovr_c[PC_OSC_IN]; // R6

    // timer compare outputs keep the port direction bit
    ovr_d[PD_CMP2].port_value_override_enable = TIMER2_COMPARE_ENABLE; // R9
    ovr_d[PD_CMP2].port_value_override_value = TIMER2_COMPARE_OUT; // R9
    ovr_d[PD_CMP_A].port_value_override_enable = TIMER1_COMPARE_A_ENABLE; // R10
    ovr_d[PD_CMP_A].port_value_override_value = TIMER1_COMPARE_A_OUT; // R10
    ovr_d[PD_CMP_B].port_value_override_enable = TIMER1_COMPARE_B_ENABLE; // R11
    ovr_d[PD_CMP_B].port_value_override_value = TIMER1_COMPARE_B_OUT; // R11

    // external interrupt inputs stay readable during sleep input gating
    ovr_d[PD_IRQ0].input_enable_override_enable = EXT_IRQ_ZERO_ENABLE; // R13
    ovr_d[PD_IRQ0].input_enable_override_value = 1'b1; // R13
    ovr_d[PD_IRQ1].input_enable_override_enable = EXT_IRQ_ONE_ENABLE; // R13
    ovr_d[PD_IRQ1].input_enable_override_value = 1'b1; // R13

    ovr_d[PD_TXD] = '{
      pullup_override_enable: UART_TX_ENABLE,
      pullup_override_value: 1'b0, // R14
      direction_override_enable: UART_TX_ENABLE,
      direction_override_value: 1'b1, // R14
      port_value_override_enable: UART_TX_ENABLE,
      port_value_override_value: UART_TX_DATA, // R14
      input_enable_override_enable: 1'b0,
      input_enable_override_value: 1'b0
    };
    ovr_d[PD_RXD] = '{
      pullup_override_enable: UART_RX_ENABLE,
      pullup_override_value: PORTD_DATA[PD_RXD] & ~pu_off, // R16
      direction_override_enable: UART_RX_ENABLE,
      direction_override_value: 1'b0, // R15
      port_value_override_enable: 1'b0,
      port_value_override_value: 1'b0,
      input_enable_override_enable: 1'b0,
      input_enable_override_value: 1'b0
    };
  end

  always_comb begin
    s_d = s_q;
    for (int i = 0; i < 8; i++) begin
      s_d.pc_ctl[i] = apply_ovr(ovr_c[i], PORTC_DATA[i], PORTC_DIRECTION[i], pu_off, die_norm);
      s_d.pd_ctl[i] = apply_ovr(ovr_d[i], PORTD_DATA[i], PORTD_DIRECTION[i], pu_off, die_norm);
      s_d.pc_di[i] = PORTC_PIN_IN[i] & s_d.pc_ctl[i].die;
      s_d.pd_di[i] = PORTD_PIN_IN[i] & s_d.pd_ctl[i].die; // R12
    end
    s_d.slew = {2{TWI_ENABLE_BIT}}; // R5
    // test inputs bypass the gated digital path
    s_d.test_in = {PORTC_PIN_IN[PC_TDI], PORTC_PIN_IN[PC_TMS], PORTC_PIN_IN[PC_TCK]};
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      s_q <= MUX_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // filters sit on the raw pin path, ahead of the serial logic
  spike_filter u_scl_filter (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .enable(TWI_ENABLE_BIT), // R5
    .raw_in(PORTC_PIN_IN[PC_SCL]), // R2
    .clean_out(TWI_SCL_IN)
  );

  spike_filter u_sda_filter (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .enable(TWI_ENABLE_BIT), // R5
    .raw_in(PORTC_PIN_IN[PC_SDA]), // R2
    .clean_out(TWI_SDA_IN)
  );

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      PORTC_PIN_OUT[i] = s_q.pc_ctl[i].out;
      PORTC_PIN_OE[i] = s_q.pc_ctl[i].oe;
      PORTD_PIN_OUT[i] = s_q.pd_ctl[i].out;
      PORTD_PIN_OE[i] = s_q.pd_ctl[i].oe;
      PORTD_PULLUP[i] = s_q.pd_ctl[i].pu;
    end
  end

  // test pull-ups bypass the reset so they hold through any reset
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      PORTC_PULLUP[i] = s_q.pc_ctl[i].pu | (TEST_PORT_ENABLE & TEST_PULLUP_MASK[i]); // R8
    end
  end

  assign PORTC_PIN_READ = s_q.pc_di;
  assign PORTD_PIN_READ = s_q.pd_di;
  assign TWI_SLEW_LIMIT = s_q.slew;
  assign TEST_TDI_IN = s_q.test_in[2];
  assign TEST_TMS_IN = s_q.test_in[1];
  assign TEST_TCK_IN = s_q.test_in[0];
  assign TIMER1_CAPTURE_IN = s_q.pd_di[PD_CAPTURE]; // R12
  assign EXT_IRQ_ZERO_IN = s_q.pd_di[PD_IRQ0]; // R13
  assign EXT_IRQ_ONE_IN = s_q.pd_di[PD_IRQ1]; // R13
  assign UART_RX_DATA = s_q.pd_di[PD_RXD]; // R15

endmodule

// file: pinmux_pkg.sv
// Functional notes
// [R1] TWI enable hands PC0 to serial clock
// [R2] TWI inputs filtered, pulses under 50 ns dropped
// [R3] TWI pins open drain, drive-low steers direction
// [R4] TWI pull-up follows port bit unless disabled
// [R5] TWI enable turns on slew limit, filters
// [R6] async timer2 frees PC7 and PC6 fully
// [R7] TDO driven only in shift states
// [R8] test pins pull-up forced, inputs off, reset-proof
// [R9] timer2 compare value replaces PD7 port value
// [R10] timer1 compare A replaces PD5 port value
// [R11] timer1 compare B replaces PD4 port value
// [R12] PD6 synchronized input feeds timer1 capture
// [R13] external irq enable forces PD2/PD3 input on
// [R14] transmitter forces PD1 output, pull-up off
// [R15] receiver forces PD0 input, feeds receiver
// [R16] receiver pull-up follows PD0 data bit
// [R17] asserted override enables replace register signals
package pinmux_pkg;

  localparam int PC_SCL = 0;
  localparam int PC_SDA = 1;
  localparam int PC_TCK = 2;
  localparam int PC_TMS = 3;
  localparam int PC_TDO = 4;
  localparam int PC_TDI = 5;
  localparam int PC_OSC_IN = 6;
  localparam int PC_OSC_OUT = 7;
  localparam int PD_RXD = 0;
  localparam int PD_TXD = 1;
  localparam int PD_IRQ0 = 2;
  localparam int PD_IRQ1 = 3;
  localparam int PD_CMP_B = 4;
  localparam int PD_CMP_A = 5;
  localparam int PD_CAPTURE = 6;
  localparam int PD_CMP2 = 7;

  localparam int CORE_CLK_MHZ = 250;
  localparam int SPIKE_NS = 50;
  // least time, rounded up to whole cycles
  localparam int SPIKE_CYCLES = (SPIKE_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int FILT_CNT_W = 4;
  localparam logic [FILT_CNT_W-1:0] FILT_LAST = FILT_CNT_W'(SPIKE_CYCLES - 1);
  localparam logic [FILT_CNT_W-1:0] FILT_CNT_RESET = 4'h0;
  localparam logic FILT_LEVEL_RESET = 1'b1;

  localparam logic [7:0] TEST_PULLUP_MASK = 8'h2C;
  localparam logic [7:0] DI_RESET = 8'h00;
  localparam logic [1:0] SLEW_RESET = 2'h0;
  localparam logic [2:0] TEST_IN_RESET = 3'h0;

  typedef struct packed {
    logic pullup_override_enable;
    logic pullup_override_value;
    logic direction_override_enable;
    logic direction_override_value;
    logic port_value_override_enable;
    logic port_value_override_value;
    logic input_enable_override_enable;
    logic input_enable_override_value;
  } pin_ovr_s;

  typedef struct packed {
    logic pu;
    logic oe;
    logic out;
    logic die;
  } pin_ctl_s;

  localparam pin_ovr_s OVR_NONE = '0;
  localparam pin_ctl_s CTL_RESET = '0;

  typedef struct packed {
    logic [FILT_CNT_W-1:0] cnt;
    logic level;
  } filt_state_s;

  typedef struct packed {
    pin_ctl_s [7:0] pc_ctl;
    pin_ctl_s [7:0] pd_ctl;
    logic [7:0] pc_di;
    logic [7:0] pd_di;
    logic [1:0] slew;
    logic [2:0] test_in;
  } mux_state_s;

  localparam mux_state_s MUX_RESET = '{
    pc_ctl: {8{CTL_RESET}},
    pd_ctl: {8{CTL_RESET}},
    pc_di: DI_RESET,
    pd_di: DI_RESET,
    slew: SLEW_RESET,
    test_in: TEST_IN_RESET
  };

endpackage

// file: spike_filter.sv
`timescale 1ns/1ps
module spike_filter
  import pinmux_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic raw_in,
  output logic clean_out
);

  filt_state_s s_q;
  filt_state_s s_d;

  // a new level is accepted only after it held for the full spike time
  always_comb begin
    s_d = s_q;
    if (!enable) begin
      s_d.cnt = FILT_CNT_RESET;
      s_d.level = FILT_LEVEL_RESET;
    end else if (raw_in == s_q.level) begin
      s_d.cnt = FILT_CNT_RESET; // R2
    end else if (s_q.cnt == FILT_LAST) begin
      s_d.cnt = FILT_CNT_RESET;
      s_d.level = raw_in; // R2
    end else begin
      s_d.cnt = s_q.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{cnt: FILT_CNT_RESET, level: FILT_LEVEL_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign clean_out = s_q.level;

endmodule

// file: port_cd_override_props.sv
`timescale 1ns/1ps
module port_cd_props (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] PORTC_DATA,
  input wire logic [7:0] PORTD_DATA,
  input wire logic GLOBAL_PULLUP_DISABLE,
  input wire logic TWI_ENABLE_BIT,
  input wire logic TWI_SCL_PULL_LOW,
  input wire logic TIMER2_ASYNC_SELECT,
  input wire logic TEST_PORT_ENABLE,
  input wire logic INSTR_SHIFT_STATE,
  input wire logic DATA_SHIFT_STATE,
  input wire logic TEST_DATA_OUT,
  input wire logic UART_TX_ENABLE,
  input wire logic UART_TX_DATA,
  input wire logic UART_RX_ENABLE,
  input wire logic [7:0] PORTC_PIN_OUT,
  input wire logic [7:0] PORTC_PIN_OE,
  input wire logic [7:0] PORTC_PULLUP,
  input wire logic [7:0] PORTD_PIN_OUT,
  input wire logic [7:0] PORTD_PIN_OE,
  input wire logic [7:0] PORTD_PULLUP,
  input wire logic [1:0] TWI_SLEW_LIMIT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  property p_slew; $rose(TWI_ENABLE_BIT) |=> TWI_SLEW_LIMIT == 2'h3; endproperty
  a_slew: assert property (p_slew) else $error("slew off");
  property p_odrain; TWI_ENABLE_BIT |=> PORTC_PIN_OUT[1:0] == 2'h0
    && PORTC_PIN_OE[0] == $past(TWI_SCL_PULL_LOW); endproperty
  a_odrain: assert property (p_odrain) else $error("twi drive");
  property p_twipu; TWI_ENABLE_BIT |=> PORTC_PULLUP[1:0]
    == ($past(PORTC_DATA[1:0]) & ~{2{$past(GLOBAL_PULLUP_DISABLE)}}); endproperty
  a_twipu: assert property (p_twipu) else $error("twi pullup");
  property p_osc; TIMER2_ASYNC_SELECT |=> (PORTC_PIN_OE[7:6] | PORTC_PULLUP[7:6]) == 2'h0;
  endproperty
  a_osc: assert property (p_osc) else $error("osc pins");
  property p_tdo; TEST_PORT_ENABLE |=> PORTC_PIN_OUT[4] == $past(TEST_DATA_OUT)
    && PORTC_PIN_OE[4] == ($past(INSTR_SHIFT_STATE) | $past(DATA_SHIFT_STATE)); endproperty
  a_tdo: assert property (p_tdo) else $error("tdo");
  property p_tpu; TEST_PORT_ENABLE |-> PORTC_PULLUP[5] && PORTC_PULLUP[3] && PORTC_PULLUP[2];
  endproperty
  a_tpu: assert property (p_tpu) else $error("test pullup");
  property p_tpurst; disable iff (1'b0) TEST_PORT_ENABLE |-> PORTC_PULLUP[5]
    && PORTC_PULLUP[3] && PORTC_PULLUP[2]; endproperty
  a_tpurst: assert property (p_tpurst) else $error("test pullup through reset");
  property p_tx; UART_TX_ENABLE |=> PORTD_PIN_OE[1] && !PORTD_PULLUP[1]
    && PORTD_PIN_OUT[1] == $past(UART_TX_DATA); endproperty
  a_tx: assert property (p_tx) else $error("tx pin");
  property p_rx; UART_RX_ENABLE |=> !PORTD_PIN_OE[0]
    && PORTD_PULLUP[0] == ($past(PORTD_DATA[0]) & ~$past(GLOBAL_PULLUP_DISABLE)); endproperty
  a_rx: assert property (p_rx) else $error("rx pin");
endmodule

bind port_cd_override port_cd_props props (
  .CORE_CLK(CORE_CLK),
  .SYS_RST(SYS_RST),
  .PORTC_DATA(PORTC_DATA),
  .PORTD_DATA(PORTD_DATA),
  .GLOBAL_PULLUP_DISABLE(GLOBAL_PULLUP_DISABLE),
  .TWI_ENABLE_BIT(TWI_ENABLE_BIT),
  .TWI_SCL_PULL_LOW(TWI_SCL_PULL_LOW),
  .TIMER2_ASYNC_SELECT(TIMER2_ASYNC_SELECT),
  .TEST_PORT_ENABLE(TEST_PORT_ENABLE),
  .INSTR_SHIFT_STATE(INSTR_SHIFT_STATE),
  .DATA_SHIFT_STATE(DATA_SHIFT_STATE),
  .TEST_DATA_OUT(TEST_DATA_OUT),
  .UART_TX_ENABLE(UART_TX_ENABLE),
  .UART_TX_DATA(UART_TX_DATA),
  .UART_RX_ENABLE(UART_RX_ENABLE),
  .PORTC_PIN_OUT(PORTC_PIN_OUT),
  .PORTC_PIN_OE(PORTC_PIN_OE),
  .PORTC_PULLUP(PORTC_PULLUP),
  .PORTD_PIN_OUT(PORTD_PIN_OUT),
  .PORTD_PIN_OE(PORTD_PIN_OE),
  .PORTD_PULLUP(PORTD_PULLUP),
  .TWI_SLEW_LIMIT(TWI_SLEW_LIMIT)
);

// file: pin_pads.sv
`timescale 1ns/1ps
module pin_pads (
  input wire logic [7:0] oe,
  input wire logic [7:0] drv,
  input wire logic [7:0] ext,
  output logic [7:0] pin
);
  // released pins follow the outside level
  assign pin = (oe & drv) | (~oe & ext);
endmodule

// file: tb_port_cd_override.sv
`timescale 1ns/1ps
module tb_port_cd_override;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [20:0] c = '0;
  logic [7:0] pcd = '0, pcr = '0, pdd = '0, pdr = '0, xc = 8'hFF, xd = 8'hFF;
  logic [7:0] pinc, pind, cpu, coe, cout, cdie, dpu, doe, dout, ddie, rc, rd;
  wire logic [74:0] o;
  logic [23:0] e1, e2;
  logic [24:0] e3;
  int mismatches = 0, comparisons = 0, cycles = 0;

  port_cd_override dut (.CORE_CLK(clk), .SYS_RST(rst), .PORTC_DATA(pcd),
    .PORTC_DIRECTION(pcr), .PORTD_DATA(pdd), .PORTD_DIRECTION(pdr),
    .GLOBAL_PULLUP_DISABLE(c[0]), .SLEEP_INPUT_DISABLE(c[1]), .PORTC_PIN_IN(pinc),
    .PORTD_PIN_IN(pind), .TWI_ENABLE_BIT(c[2]), .TWI_SCL_PULL_LOW(c[3]),
    .TWI_SDA_PULL_LOW(c[4]), .TIMER2_ASYNC_SELECT(c[5]), .TEST_PORT_ENABLE(c[6]),
    .INSTR_SHIFT_STATE(c[7]), .DATA_SHIFT_STATE(c[8]), .TEST_DATA_OUT(c[9]),
    .TIMER2_COMPARE_ENABLE(c[10]), .TIMER2_COMPARE_OUT(c[11]),
    .TIMER1_COMPARE_A_ENABLE(c[12]), .TIMER1_COMPARE_A_OUT(c[13]),
    .TIMER1_COMPARE_B_ENABLE(c[14]), .TIMER1_COMPARE_B_OUT(c[15]),
    .EXT_IRQ_ZERO_ENABLE(c[16]), .EXT_IRQ_ONE_ENABLE(c[17]), .UART_TX_ENABLE(c[18]),
    .UART_TX_DATA(c[19]), .UART_RX_ENABLE(c[20]), .PORTC_PIN_OUT(o[7:0]),
    .PORTC_PIN_OE(o[15:8]), .PORTC_PULLUP(o[23:16]), .PORTC_PIN_READ(o[31:24]),
    .PORTD_PIN_OUT(o[39:32]), .PORTD_PIN_OE(o[47:40]), .PORTD_PULLUP(o[55:48]),
    .PORTD_PIN_READ(o[63:56]), .TWI_SLEW_LIMIT(o[65:64]), .TWI_SCL_IN(o[66]),
    .TWI_SDA_IN(o[67]), .TEST_TCK_IN(o[68]), .TEST_TMS_IN(o[69]), .TEST_TDI_IN(o[70]),
    .TIMER1_CAPTURE_IN(o[71]), .EXT_IRQ_ZERO_IN(o[72]), .EXT_IRQ_ONE_IN(o[73]),
    .UART_RX_DATA(o[74]));
  pin_pads pads_c (.oe(o[15:8]), .drv(o[7:0]), .ext(xc), .pin(pinc));
  pin_pads pads_d (.oe(o[47:40]), .drv(o[39:32]), .ext(xd), .pin(pind));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic calc;
    cpu = pcd & ~pcr & {8{~c[0]}};
    coe = pcr;
    cout = pcd;
    cdie = {8{~c[1]}};
    dpu = pdd & ~pdr & {8{~c[0]}};
    doe = pdr;
    dout = pdd;
    ddie = cdie;
    if (c[2]) begin
      cpu[1:0] = pcd[1:0] & {2{~c[0]}};
      coe[1:0] = c[4:3];
      cout[1:0] = 2'h0;
    end
    if (c[6]) begin
      cpu[5:2] = 4'hB;
      coe[5:2] = {1'b0, c[7] | c[8], 2'h0};
      cout[4] = c[9];
      cdie[5:2] = 4'h0;
    end
    if (c[5]) begin
      cpu[7:6] = 2'h0;
      coe[7:6] = 2'h0;
      cdie[7:6] = 2'h0;
    end
    if (c[10]) dout[7] = c[11];
    if (c[12]) dout[5] = c[13];
    if (c[14]) dout[4] = c[15];
    if (c[16]) ddie[2] = 1'b1;
    if (c[17]) ddie[3] = 1'b1;
    if (c[18]) begin
      dpu[1] = 1'b0;
      doe[1] = 1'b1;
      dout[1] = c[19];
    end
    if (c[20]) begin
      dpu[0] = pdd[0] & ~c[0];
      doe[0] = 1'b0;
    end
    rc = pinc & cdie;
    rd = pind & ddie;
    e1 = {cpu, coe, cout};
    e2 = {dpu, doe, dout};
    e3 = {rd[0], rd[3], rd[2], rd[6], pinc[5], pinc[3], pinc[2], {2{c[2]}}, rd, rc};
  endtask

  // held low for n cycles, then released
  task automatic low_pulse(input int n, input logic want);
    xc[1:0] = 2'h0;
    repeat (n) @(negedge clk);
    chk(32'(o[67:66]), 32'({2{want}}));
    xc[1:0] = 2'h3;
    repeat (20) @(negedge clk);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      end_of_test;
    end
  end

  initial begin
    void'($urandom(37565));
    repeat (6) @(negedge clk);
    chk(32'({o[15:8], o[47:40], o[66]}), 32'h1);
    rst = 1'b0;
    calc;
    for (int i = 0; i < 2000; i++) begin
      @(negedge clk);
      chk(32'(o[23:0]), 32'(e1));
      chk(32'(o[55:32]), 32'(e2));
      chk(32'({o[74:68], o[65:56], o[31:24]}), 32'(e3));
      if (!c[2]) chk(32'(o[67:66]), 32'h3);
      c = (i == 0) ? '1 : (i == 1) ? '0 : 21'($urandom);
      {pcd, pcr, pdd, pdr} = $urandom;
      {xc, xd} = 16'($urandom);
      #1 calc;
    end
    c = 21'h4;
    xc = 8'hFF;
    repeat (20) @(negedge clk);
    low_pulse(12, 1'b1);
    low_pulse(13, 1'b0);
    // second reset with the test port on
    c = 21'h40;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    chk(32'(o[23:16]), 32'h2C);
    rst = 1'b0;
    #1 calc;
    @(negedge clk);
    chk(32'(o[23:0]), 32'(e1));
    end_of_test;
  end
endmodule
